/* File: sbc_pkg.sv */
// Package with register map, field positions and reset values of the serial port core
package sbc_pkg;
  // ==========================================
  // Register byte addresses
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_BAUD = 8'h08;
  localparam logic [7:0] ADDR_TXD = 8'h0c;
  localparam logic [7:0] ADDR_RXD = 8'h10;
  localparam logic [7:0] ADDR_IRQS = 8'h14;
  localparam logic [7:0] ADDR_IRQM = 8'h18;
  // ==========================================
  // Mode register fields
  localparam int MODE_EN = 15;
  localparam int MODE_IDLE_STOP = 13;
  localparam int MODE_IR = 12;
  localparam int MODE_RTS = 11;
  localparam int MODE_PINS_LO = 8;
  localparam int MODE_WAKE = 7;
  localparam int MODE_LOOP = 6;
  localparam int MODE_RATE_AUTODETECT = 5;
  localparam int MODE_RX_POLARITY_INVERT = 4;
  localparam int MODE_HS = 3;
  localparam int MODE_STOP2 = 0;
  localparam logic [15:0] MODE_WMASK = 16'hbbff;
  // ==========================================
  // Status register fields
  localparam int STA_TXINV = 14;
  localparam int STA_TXEN = 10;
  localparam int STA_TXBF = 9;
  localparam int STA_TX_IDLE_FLAG = 8;
  localparam int STA_RXSEL_LO = 6;
  localparam int STA_RX_IDLE_FLAG = 4;
  localparam int STA_FRAMING_ERROR_FLAG = 2;
  localparam int STA_OVERRUN_FLAG = 1;
  localparam int STA_RXDA = 0;
  // ==========================================
  // Interrupt status bits
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_WAKE = 2;
  localparam int IRQ_ERR = 3;
  localparam int IRQ_W = 4;
  // ==========================================
  // Reset values and counts
  localparam logic [15:0] BAUD_RESET = 16'h0000;
  localparam logic [3:0] OVS_NORMAL = 4'hf;
  localparam logic [3:0] OVS_FAST = 4'h3;
  localparam logic [3:0] RX_THRESH3 = 4'h3;
  localparam int DATA_BITS = 8;
endpackage : sbc_pkg

/* File: sbc_baud.sv */
// Baud timer: free running divisor counter and sample-rate prescaler
`timescale 1ns/1ps
`default_nettype none
module sbc_baud import sbc_pkg::*; #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Control
  input wire logic [W-1:0] divisor,
  input wire logic div_write,
  input wire logic high_speed,
  // Ticks
  output logic sample_tick,
  output logic bit_tick
);
  logic [W-1:0] cnt;
  logic [3:0] ovs;
  logic [3:0] ovs_top;

  assign ovs_top = high_speed ? OVS_FAST : OVS_NORMAL;

  // ==========================================
  // Divisor timer, restarted by any divisor write
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt <= '0;
      sample_tick <= 1'b0;
    end else if (div_write) begin
      cnt <= '0;
      sample_tick <= 1'b0;
    end else if (cnt >= divisor) begin
      cnt <= '0;
      sample_tick <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      sample_tick <= 1'b0;
    end
  end

  // ==========================================
  // Oversample prescaler: bit tick every 16 or 4 samples
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ovs <= '0;
      bit_tick <= 1'b0;
    end else if (div_write) begin
      ovs <= '0;
      bit_tick <= 1'b0;
    end else if (sample_tick) begin
      ovs <= (ovs >= ovs_top) ? 4'h0 : ovs + 4'h1;
      bit_tick <= (ovs >= ovs_top);
    end else begin
      bit_tick <= 1'b0;
    end
  end
endmodule : sbc_baud
`default_nettype wire

/* File: sbc_fifo.sv */
// Small flip-flop FIFO used for the transmit and receive character buffers
`timescale 1ns/1ps
`default_nettype none
module sbc_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  input wire logic flush,
  // Write side
  input wire logic wr,
  input wire logic [W-1:0] wdata,
  // Read side
  input wire logic rd,
  output logic [W-1:0] rdata,
  // Level
  output logic [$clog2(D+1)-1:0] level
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic do_wr;
  logic do_rd;

  assign do_rd = rd && (level != 0);
  assign do_wr = wr && (level != D[$clog2(D+1)-1:0]);
  assign rdata = mem[rp];

  always_ff @(posedge mclk) begin
    if (do_wr) begin
      mem[wp] <= wdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wp <= '0;
      rp <= '0;
      level <= '0;
    end else if (flush) begin
      wp <= '0;
      rp <= '0;
      level <= '0;
    end else begin
      if (do_wr) begin
        wp <= wp + 1'b1;
      end
      if (do_rd) begin
        rp <= rp + 1'b1;
      end
      level <= level + (do_wr ? 1'b1 : 1'b0) - (do_rd ? 1'b1 : 1'b0);
    end
  end
endmodule : sbc_fifo
`default_nettype wire

/* File: sbc_uart.sv */
// Serial port core: APB registers, baud timer, transmitter, receiver, interrupts
// Operation
// - Free-running 16-bit baud timer set by divisor
// - Normal speed: clock over 16 times (divisor+1)
// - High speed: clock over 4 times (divisor+1)
// - Divisor write clears baud timer at once
// - Idle polarity bit sets transmit idle level
// - Transmit disable aborts, flushes, releases pin
// - Buffer-full flag while no room remains
// - Idle flag when shifter and buffer empty
// - Select 10 interrupts on third character
`timescale 1ns/1ps
`default_nettype none
module sbc_uart import sbc_pkg::*; #(
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_oe,
  // Power state
  input wire logic sleep_mode,
  // Interrupt
  output logic irq
);
  localparam int LW = $clog2(DEPTH+1);
  typedef enum logic [1:0] {SBC_IDLE, SBC_START, SBC_DATA, SBC_STOP} sbc_state_t;

  logic [15:0] mode;
  logic [15:0] stactl;
  logic [15:0] baud_divisor;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic wr_en;
  logic div_write;
  logic sample_tick;
  logic bit_tick;
  logic module_enable;
  logic transmit_enable;
  logic tx_flush;
  logic txf_push;
  logic txf_pop;
  logic [7:0] txf_data;
  logic [LW-1:0] txf_level;
  logic rxf_push;
  logic rxf_pop;
  logic [7:0] rxf_data;
  logic [7:0] rx_shift;
  logic [LW-1:0] rxf_level;
  logic tx_buffer_full;
  logic tx_idle_flag;
  logic idle_level;
  logic rx_line;
  logic rx_prev;
  logic rx_event;
  logic wake_event;
  logic err_event;
  logic framing_error_flag;
  logic overrun_flag;
  logic [IRQ_W-1:0] irq_set;

  assign module_enable = mode[MODE_EN];
  assign transmit_enable = stactl[STA_TXEN];
  assign wr_en = psel && penable && pwrite;
  assign div_write = wr_en && (paddr == ADDR_BAUD);
  assign tx_flush = !transmit_enable || !module_enable;

  // ==========================================
  // Baud timer and character buffers
  sbc_baud #(.W(16)) u_baud (
    .mclk(mclk),
    .rstn(rstn),
    .divisor(baud_divisor),
    .div_write(div_write),
    .high_speed(mode[MODE_HS]),
    .sample_tick(sample_tick),
    .bit_tick(bit_tick)
  );

  assign tx_buffer_full = (txf_level == DEPTH[LW-1:0]);
  assign txf_push = wr_en && (paddr == ADDR_TXD) && !tx_flush && !tx_buffer_full;

  sbc_fifo #(.W(8), .D(DEPTH)) u_txf (
    .mclk(mclk),
    .rstn(rstn),
    .flush(tx_flush),
    .wr(txf_push),
    .wdata(pwdata[7:0]),
    .rd(txf_pop),
    .rdata(txf_data),
    .level(txf_level)
  );

  assign rxf_pop = psel && penable && !pwrite && (paddr == ADDR_RXD);

  sbc_fifo #(.W(8), .D(DEPTH)) u_rxf (
    .mclk(mclk),
    .rstn(rstn),
    .flush(!module_enable),
    .wr(rxf_push),
    .wdata(rx_shift),
    .rd(rxf_pop),
    .rdata(rxf_data),
    .level(rxf_level)
  );

  // ==========================================
  // Transmitter
  sbc_state_t tx_state;
  logic [7:0] tx_shift;
  logic [2:0] tx_bits;
  logic tx_stop2;
  logic tx_line;

  assign txf_pop = (tx_state == SBC_IDLE) && bit_tick && (txf_level != 0) && !tx_flush;
  assign tx_idle_flag = (tx_state == SBC_IDLE) && (txf_level == 0);
  // Polarity sense flips with the infrared codec
  assign idle_level = ~(stactl[STA_TXINV] ^ mode[MODE_IR]);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tx_state <= SBC_IDLE;
      tx_shift <= 8'h00;
      tx_bits <= 3'h0;
      tx_stop2 <= 1'b0;
      tx_line <= 1'b1;
    end else if (tx_flush) begin
      tx_state <= SBC_IDLE;
      tx_line <= 1'b1;
    end else if (bit_tick) begin
      unique case (tx_state)
        SBC_IDLE: begin
          tx_line <= 1'b1;
          if (txf_level != 0) begin
            tx_shift <= txf_data;
            tx_line <= 1'b0;
            tx_state <= SBC_DATA;
            tx_bits <= 3'h0;
          end
        end
        SBC_START: begin
          tx_state <= SBC_DATA;
        end
        SBC_DATA: begin
          tx_line <= tx_shift[0];
          tx_shift <= {1'b0, tx_shift[7:1]};
          tx_bits <= tx_bits + 3'h1;
          if (tx_bits == 3'(DATA_BITS - 1)) begin
            tx_state <= SBC_STOP;
            tx_stop2 <= mode[MODE_STOP2];
          end
        end
        SBC_STOP: begin
          tx_line <= 1'b1;
          if (tx_stop2) begin
            tx_stop2 <= 1'b0;
          end else begin
            tx_state <= SBC_IDLE;
          end
        end
      endcase
    end
  end

  // Pin ownership follows the enable bits; port logic owns it otherwise
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      serial_out_pin <= 1'b1;
      serial_out_oe <= 1'b0;
    end else begin
      serial_out_oe <= module_enable && transmit_enable;
      serial_out_pin <= tx_line ? idle_level : ~idle_level;
    end
  end

  // ==========================================
  // Receiver: samples centred on the oversample grid
  sbc_state_t rx_state;
  logic [2:0] rx_bits;
  logic [3:0] rx_ovs;
  logic [3:0] ovs_top;

  assign ovs_top = mode[MODE_HS] ? OVS_FAST : OVS_NORMAL;
  assign rx_line = (mode[MODE_LOOP] ? tx_line : serial_in_pin) ^ mode[MODE_RX_POLARITY_INVERT];

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rx_state <= SBC_IDLE;
      rx_shift <= 8'h00;
      rx_bits <= 3'h0;
      rx_ovs <= 4'h0;
      rxf_push <= 1'b0;
      framing_error_flag <= 1'b0;
    end else begin
      rxf_push <= 1'b0;
      if (!module_enable) begin
        rx_state <= SBC_IDLE;
      end else if (sample_tick) begin
        rx_ovs <= rx_ovs + 4'h1;
        unique case (rx_state)
          SBC_IDLE: begin
            rx_ovs <= 4'h0;
            if (!rx_line) begin
              rx_state <= SBC_START;
            end
          end
          SBC_START: begin
            if (rx_ovs == {1'b0, ovs_top[3:1]}) begin
              rx_ovs <= 4'h0;
              rx_bits <= 3'h0;
              rx_state <= rx_line ? SBC_IDLE : SBC_DATA;
            end
          end
          SBC_DATA: begin
            if (rx_ovs == ovs_top) begin
              rx_ovs <= 4'h0;
              rx_shift <= {rx_line, rx_shift[7:1]};
              rx_bits <= rx_bits + 3'h1;
              if (rx_bits == 3'(DATA_BITS - 1)) begin
                rx_state <= SBC_STOP;
              end
            end
          end
          SBC_STOP: begin
            if (rx_ovs == ovs_top) begin
              rx_state <= SBC_IDLE;
              rxf_push <= 1'b1;
              framing_error_flag <= !rx_line;
            end
          end
        endcase
      end
    end
  end

  assign overrun_flag = rxf_push && (rxf_level == DEPTH[LW-1:0]);

  // Receive interrupt: level before this push decides the threshold
  always_comb begin
    rx_event = 1'b0;
    if (rxf_push && !overrun_flag) begin
      unique case (stactl[STA_RXSEL_LO +: 2])
        2'b10: rx_event = (rxf_level == LW'(RX_THRESH3 - 4'h1));
        2'b11: rx_event = (rxf_level == LW'(DEPTH - 1));
        default: rx_event = 1'b1;
      endcase
    end
  end

  // ==========================================
  // Wake-on-start: watch the pin while asleep
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rx_prev <= 1'b1;
    end else begin
      rx_prev <= rx_line;
    end
  end
  assign wake_event = mode[MODE_WAKE] && sleep_mode && rx_prev && !rx_line;
  assign err_event = rxf_push && (framing_error_flag || overrun_flag);

  // ==========================================
  // Registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mode <= 16'h0000;
      baud_divisor <= BAUD_RESET;
      stactl <= 16'h0000;
      irq_mask <= '0;
    end else begin
      if (wr_en && paddr == ADDR_MODE) begin
        mode <= pwdata[15:0] & MODE_WMASK;
      end else if (mode[MODE_WAKE] && !rx_prev && rx_line) begin
        mode[MODE_WAKE] <= 1'b0;
      end
      if (div_write) begin
        baud_divisor <= pwdata[15:0];
      end
      if (wr_en && paddr == ADDR_STAT) begin
        stactl <= pwdata[15:0] & 16'he4e0;
      end
      if (wr_en && paddr == ADDR_IRQM) begin
        irq_mask <= pwdata[IRQ_W-1:0];
      end
    end
  end

  assign irq_set = {err_event, wake_event, txf_pop, rx_event};

  // Sticky events; a set in the clearing cycle survives
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq_stat <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_en && paddr == ADDR_IRQS) begin
        irq_stat <= (irq_stat & ~pwdata[IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat <= irq_stat | irq_set;
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

  // APB read: one wait-free access phase
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        pslverr <= !(paddr inside {ADDR_MODE, ADDR_STAT, ADDR_BAUD, ADDR_TXD, ADDR_RXD, ADDR_IRQS, ADDR_IRQM});
        unique case (paddr)
          ADDR_MODE: prdata <= {16'h0000, mode};
          ADDR_STAT: prdata <= {16'h0000, stactl[15:10], tx_buffer_full, tx_idle_flag,
            stactl[7:5], rx_state == SBC_IDLE, 1'b0, framing_error_flag, 1'b0, rxf_level != 0};
          ADDR_BAUD: prdata <= {16'h0000, baud_divisor};
          ADDR_RXD: prdata <= {24'h000000, rxf_data};
          ADDR_IRQS: prdata <= {28'h0000000, irq_stat};
          ADDR_IRQM: prdata <= {28'h0000000, irq_mask};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================
  // Checks
  a_div_clears: assert property (@(posedge mclk) disable iff (!rstn)
    div_write |=> !sample_tick ##0 !bit_tick) else $error("divisor write did not restart timer");
  a_full_flag: assert property (@(posedge mclk) disable iff (!rstn)
    (txf_push && !txf_pop && txf_level == LW'(DEPTH - 1)) |=> tx_buffer_full) else $error("full flag missed");
  a_idle_flag: assert property (@(posedge mclk) disable iff (!rstn)
    txf_push |=> !tx_idle_flag) else $error("idle flag set with queued data");
  a_txen_abort: assert property (@(posedge mclk) disable iff (!rstn)
    !transmit_enable |=> txf_level == 0 && !serial_out_oe) else $error("disable did not flush");
  a_pin_owner: assert property (@(posedge mclk) disable iff (!rstn)
    serial_out_oe |-> $past(module_enable)) else $error("pin driven while disabled");
  a_idle_level: assert property (@(posedge mclk) disable iff (!rstn)
    (tx_state == SBC_IDLE && tx_line && $stable(idle_level)) |=> serial_out_pin == $past(idle_level))
    else $error("wrong idle level");
  a_wake_irq: assert property (@(posedge mclk) disable iff (!rstn)
    wake_event |=> irq_stat[IRQ_WAKE]) else $error("wake edge lost");
  a_rx_third: assert property (@(posedge mclk) disable iff (!rstn)
    (rxf_push && stactl[7:6] == 2'b10 && rxf_level == 2) |=> irq_stat[IRQ_RX]) else $error("no threshold irq");
  a_tx_start: assert property (@(posedge mclk) disable iff (!rstn)
    txf_pop |=> !tx_line) else $error("no start bit");
endmodule : sbc_uart
`default_nettype wire

/* File: sbc_remote.sv */
// Remote serial device model that sends and receives asynchronous frames
`timescale 1ns/1ps
`default_nettype none
module sbc_remote (
  // Clock
  input wire logic mclk,
  // Serial lines
  input wire logic line_in,
  output logic line_out
);
  // ==========================================
  // State
  int bit_cyc = 16;
  int n_got = 0;
  logic [7:0] got = 8'h00;
  logic [7:0] shreg;

  initial begin
    line_out = 1'b1;
  end

  // ==========================================
  // Receiver
  // Samples mid-bit so a late edge still reads clean
  always begin
    @(negedge line_in);
    repeat (bit_cyc / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge mclk);
      shreg[i] = line_in;
    end
    repeat (bit_cyc) @(posedge mclk);
    got = shreg;
    n_got++;
  end

  // ==========================================
  // Transmitter
  // The gap lets the model answer promptly or slowly
  task automatic send(input logic [7:0] b, input int gap);
    line_out <= 1'b0;
    repeat (bit_cyc) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      line_out <= b[i];
      repeat (bit_cyc) @(posedge mclk);
    end
    line_out <= 1'b1;
    repeat (bit_cyc + gap) @(posedge mclk);
  endtask : send
endmodule : sbc_remote
`default_nettype wire

/* File: testbench.sv */
// Self-checking testbench for the serial port core
`timescale 1ns/1ps
`default_nettype none
module testbench import sbc_pkg::*; ;
  // ==========================================
  // Signals
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, serial_in_pin, serial_out_pin, serial_out_oe, irq;
  logic sleep_mode = 1'b0;
  logic last_err;
  int error_cnt = 0;
  int n_checks = 0;

  always #25 mclk = ~mclk;

  sbc_uart #(.DEPTH(4)) sbc_uart_i (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .serial_out_oe(serial_out_oe), .sleep_mode(sleep_mode), .irq(irq));
  // Undriven pin idles high, as the port pull-up holds it
  sbc_remote remote_i (.mclk(mclk), .line_in(serial_out_oe ? serial_out_pin : 1'b1), .line_out(serial_in_pin));

  // ==========================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t ns: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Read data and error are taken at the edge where pready is sampled high; only the watchdog ends a wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r & m, e);
  endtask : rc

  task automatic ticks(input int n);
    repeat (n) @(posedge mclk);
  endtask : ticks

  // Length of the start bit in clocks; data LSB is 1 so it stands alone
  task automatic start_len(output int n);
    int t;
    t = 0;
    n = 0;
    while (serial_out_pin !== 1'b0 && t < 2000) begin
      @(negedge mclk);
      t++;
    end
    while (serial_out_pin === 1'b0 && n < 2000) begin
      @(negedge mclk);
      n++;
    end
  endtask : start_len

  task automatic wait_rx(input int old);
    int t;
    t = 0;
    while (remote_i.n_got == old && t < 2000) begin
      @(posedge mclk);
      t++;
    end
    chk({31'h0, remote_i.n_got != old}, 32'h1);
  endtask : wait_rx

  // ==========================================
  // Scenarios
  task automatic t_reset();
    rc(ADDR_MODE, 32'hffffffff, 32'h0);
    rc(ADDR_STAT, 32'hffffffff, 32'h00000110);
    rc(ADDR_BAUD, 32'hffffffff, {16'h0, BAUD_RESET});
    rc(8'h1c, 32'hffffffff, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    chk({30'h0, serial_out_oe, serial_out_pin}, 32'h1);
  endtask : t_reset

  task automatic t_tx();
    int n, old;
    wr(ADDR_BAUD, 32'h1);
    wr(ADDR_MODE, 32'h8000);
    wr(ADDR_STAT, 32'h0400);
    remote_i.bit_cyc = 32;
    old = remote_i.n_got;
    wr(ADDR_TXD, 32'ha5);
    start_len(n);
    chk(32'(n), 32'd32);
    rc(ADDR_STAT, 32'h300, 32'h0);
    wait_rx(old);
    chk({24'h0, remote_i.got}, 32'ha5);
    chk({31'h0, serial_out_oe}, 32'h1);
    ticks(40);
    rc(ADDR_STAT, 32'h100, 32'h100);
    wr(ADDR_BAUD, 32'h0);
    wr(ADDR_MODE, 32'h8008);
    remote_i.bit_cyc = 4;
    old = remote_i.n_got;
    wr(ADDR_TXD, 32'ha5);
    start_len(n);
    chk(32'(n), 32'd4);
    wait_rx(old);
    chk({24'h0, remote_i.got}, 32'ha5);
    ticks(10);
    repeat (6) wr(ADDR_TXD, 32'h3c);
    rc(ADDR_STAT, 32'h300, 32'h200);
    wr(ADDR_STAT, 32'h0);
    rc(ADDR_STAT, 32'h300, 32'h100);
    chk({31'h0, serial_out_oe}, 32'h0);
    wr(ADDR_STAT, 32'h4400);
    ticks(4);
    chk({31'h0, serial_out_pin}, 32'h0);
    wr(ADDR_STAT, 32'h0400);
    ticks(4);
    chk({31'h0, serial_out_pin}, 32'h1);
    wr(ADDR_STAT, 32'h0);
  endtask : t_tx

  // Threshold modes: select 10 fires on 3rd char, 11 on full, 00 and 01 on each
  task automatic t_rx();
    logic [1:0] sel [4] = '{2'b10, 2'b11, 2'b00, 2'b01};
    int cnt [4] = '{3, 4, 1, 1};
    wr(ADDR_MODE, 32'h8000);
    wr(ADDR_IRQM, 32'h1);
    remote_i.bit_cyc = 16;
    rc(ADDR_IRQS, 32'h2, 32'h2);
    chk({31'h0, irq}, 32'h0);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_STAT, {24'h0, sel[k], 6'h0});
      wr(ADDR_IRQS, 32'hf);
      for (int i = 0; i < cnt[k]; i++) begin
        rc(ADDR_IRQS, 32'h1, 32'h0);
        remote_i.send(8'(8'h40 + i), 2);
      end
      ticks(4);
      rc(ADDR_IRQS, 32'h1, 32'h1);
      chk({31'h0, irq}, 32'h1);
      for (int i = 0; i < cnt[k]; i++) begin
        rc(ADDR_RXD, 32'hff, 32'(32'h40 + i));
      end
      rc(ADDR_STAT, 32'h1, 32'h0);
      wr(ADDR_IRQS, 32'hf);
      ticks(2);
      chk({31'h0, irq}, 32'h0);
    end
  endtask : t_rx

  task automatic t_wake();
    sleep_mode <= 1'b1;
    wr(ADDR_IRQM, 32'h4);
    wr(ADDR_IRQS, 32'hf);
    wr(ADDR_MODE, 32'h8080);
    rc(ADDR_MODE, 32'h80, 32'h80);
    rc(ADDR_IRQS, 32'h4, 32'h0);
    remote_i.send(8'hff, 4);
    rc(ADDR_IRQS, 32'h4, 32'h4);
    rc(ADDR_MODE, 32'h80, 32'h0);
    chk({31'h0, irq}, 32'h1);
    sleep_mode <= 1'b0;
  endtask : t_wake

  // ==========================================
  // Run control
  task automatic conclude();
    $display("Checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_wake();
    conclude();
  end

  // The full run needs a few thousand clocks; this leaves ample margin
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    conclude();
  end
endmodule : testbench
`default_nettype wire
